// ---- core/bst_pkg.sv ----
package bst_pkg;

    // pin and cell counts
    localparam int BST_N_IO      = 68;
    localparam int BST_N_IN      = 4;
    localparam int BST_N_MC      = 64;
    localparam int BST_N_TAP     = 4;

    // boundary chain layout, index 0 sits next to the serial output
    localparam int BST_MC_BASE   = 0;
    localparam int BST_IN_BASE   = BST_MC_BASE + BST_N_MC;
    localparam int BST_IO_BASE   = BST_IN_BASE + BST_N_IN;
    localparam int BST_IO_CELLS  = 3;
    localparam int BST_F_IN      = 0;
    localparam int BST_F_OUT     = 1;
    localparam int BST_F_OE      = 2;
    localparam int BST_BSR_LEN   = BST_IO_BASE + BST_IO_CELLS * BST_N_IO;

    // test port pin positions in the four-pin group
    localparam int BST_P_TDI     = 0;
    localparam int BST_P_TMS     = 1;
    localparam int BST_P_TCK     = 2;
    localparam int BST_P_TDO     = 3;

    // instruction register
    localparam int          BST_IR_LEN     = 4;
    localparam logic [3:0]  BST_IR_CAPTURE = 4'h1;
    localparam logic [3:0]  BST_IR_IDCODE  = 4'h2;
    localparam logic [3:0]  BST_IR_EXTEST  = 4'h0;
    localparam logic [3:0]  BST_IR_SAMPLE  = 4'h1;
    localparam logic [3:0]  BST_IR_HIGHZ   = 4'h3;
    localparam logic [3:0]  BST_IR_BYPASS  = 4'hF;

    // identification word, value is arbitrary (lsb must be one)
    localparam logic [31:0] BST_IDCODE     = 32'h1234_5679;
    localparam int          BST_ID_LEN     = 32;

    // link sample buffer: {tms, tdi} per rising test clock edge
    localparam int BST_FIFO_W     = 2;
    localparam int BST_FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } bst_tap_e;

    typedef enum logic [1:0] {
        SEL_BYP, SEL_ID, SEL_BSR
    } bst_sel_e;

endpackage

// ---- core/bst_fifo.sv ----
`timescale 1ns/1ps
module bst_fifo #(
    parameter int W     = 2,
    parameter int DEPTH = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             cnt;
    } bst_fifo_s;

    bst_fifo_s s_q;
    bst_fifo_s s_d;
    logic      push;
    logic      pop;

    assign o_in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.cnt != '0);
    assign o_out_data  = s_q.mem[s_q.rptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wptr] = i_in_data;
            s_d.wptr          = s_q.wptr + AW'(1);
        end
        if (pop) begin
            s_d.rptr = s_q.rptr + AW'(1);
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    fifo_full_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_q.cnt <= (AW+1)'(DEPTH))
        else $error("buffer count beyond its depth");
    fifo_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (push && !pop) |=> (s_q.cnt == $past(s_q.cnt) + (AW+1)'(1)))
        else $error("buffer count missed a push");
endmodule // bst_fifo

// ---- core/bst_tap.sv ----
`timescale 1ns/1ps
module bst_tap
(
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_jtag_en,
    input  wire logic                          i_pullup_en,
    input  wire logic [bst_pkg::BST_N_TAP-1:0] i_tap_pin,
    output logic      [bst_pkg::BST_N_TAP-1:0] o_tap_pin_out,
    output logic      [bst_pkg::BST_N_TAP-1:0] o_tap_pin_oe,
    input  wire logic [bst_pkg::BST_N_TAP-1:0] i_usr_tap_out,
    input  wire logic [bst_pkg::BST_N_TAP-1:0] i_usr_tap_oe,
    output logic      [bst_pkg::BST_N_TAP-1:0] o_usr_tap_in,
    output logic                               o_tms_pu,
    output logic                               o_tdi_pu,
    input  wire logic [bst_pkg::BST_N_IO-1:0]  i_pin_in,
    output logic      [bst_pkg::BST_N_IO-1:0]  o_pin_out,
    output logic      [bst_pkg::BST_N_IO-1:0]  o_pin_oe,
    input  wire logic [bst_pkg::BST_N_IN-1:0]  i_ded_in,
    output logic      [bst_pkg::BST_N_IN-1:0]  o_core_ded,
    output logic      [bst_pkg::BST_N_IO-1:0]  o_core_in,
    input  wire logic [bst_pkg::BST_N_IO-1:0]  i_core_out,
    input  wire logic [bst_pkg::BST_N_IO-1:0]  i_core_oe,
    input  wire logic [bst_pkg::BST_N_MC-1:0]  i_mc_state,
    output logic                               o_link_overrun
);
    import bst_pkg::*;

    typedef struct packed {
        bst_tap_e                st;
        logic [BST_IR_LEN-1:0]   ir;
        logic [BST_IR_LEN-1:0]   ir_sh;
        logic [BST_BSR_LEN-1:0]  bsr;
        logic [BST_ID_LEN-1:0]   id_sh;
        logic                    byp;
        logic [BST_N_IO-1:0]     upd_out;
        logic [BST_N_IO-1:0]     upd_oe;
        logic [BST_N_IO-1:0]     sy1_io;
        logic [BST_N_IO-1:0]     sy2_io;
        logic [BST_N_IN-1:0]     sy1_ded;
        logic [BST_N_IN-1:0]     sy2_ded;
        logic [BST_N_TAP-1:0]    sy1_tap;
        logic [BST_N_TAP-1:0]    sy2_tap;
        logic                    tck_prev;
        logic                    busy;
        logic                    tdo;
        logic                    tdo_oe;
        logic [BST_N_TAP-1:0]    tap_out;
        logic [BST_N_TAP-1:0]    tap_oe;
        logic [BST_N_TAP-1:0]    usr_tap_in;
        logic                    tms_pu;
        logic                    tdi_pu;
        logic [BST_N_IO-1:0]     pin_out;
        logic [BST_N_IO-1:0]     pin_oe;
        logic [BST_N_IO-1:0]     core_in;
        logic [BST_N_IN-1:0]     core_ded;
        logic                    overrun;
    } bst_tap_s;

    bst_tap_s               s_q;
    bst_tap_s               s_d;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic [BST_FIFO_W-1:0]  fifo_out_data;
    logic                   pop;
    logic                   pop_tms;
    logic                   pop_tdi;

    function automatic bst_tap_e tap_next(input bst_tap_e st,
                                          input logic tms);
        case (st)
            ST_TLR:    tap_next = tms ? ST_TLR    : ST_RTI;
            ST_RTI:    tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            default:   tap_next = ST_TLR;
        endcase
    endfunction

    // unknown codes fall back to the one-bit bypass path
    function automatic bst_sel_e dr_sel(input logic [BST_IR_LEN-1:0] ir);
        case (ir)
            BST_IR_EXTEST, BST_IR_SAMPLE: dr_sel = SEL_BSR;
            BST_IR_IDCODE:                dr_sel = SEL_ID;
            default:                      dr_sel = SEL_BYP;
        endcase
    endfunction

    // only the synchronised copy of the test clock is edge-detected
    assign tck_rise = s_q.sy2_tap[BST_P_TCK] && !s_q.tck_prev;
    assign tck_fall = !s_q.sy2_tap[BST_P_TCK] && s_q.tck_prev;
    // one sample per two clocks keeps the engine simple; tck is far slower
    assign pop      = fifo_out_valid && !s_q.busy;
    assign pop_tms  = fifo_out_data[1];
    assign pop_tdi  = fifo_out_data[0];

    bst_fifo #(
        .W     (BST_FIFO_W),
        .DEPTH (BST_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (tck_rise && i_jtag_en),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({s_q.sy2_tap[BST_P_TMS], s_q.sy2_tap[BST_P_TDI]}),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (!s_q.busy),
        .o_out_data  (fifo_out_data)
    );

    always_comb begin
        s_d          = s_q;
        s_d.sy1_io   = i_pin_in;
        s_d.sy2_io   = s_q.sy1_io;
        s_d.sy1_ded  = i_ded_in;
        s_d.sy2_ded  = s_q.sy1_ded;
        s_d.sy1_tap  = i_tap_pin;
        s_d.sy2_tap  = s_q.sy1_tap;
        s_d.tck_prev = s_q.sy2_tap[BST_P_TCK];
        s_d.busy     = pop;
        if (tck_rise && i_jtag_en && !fifo_in_ready) begin
            s_d.overrun = 1'b1;
        end
        if (!i_jtag_en) begin
            s_d.st = ST_TLR;
            s_d.ir = BST_IR_IDCODE;
        end else if (pop) begin
            // strobes below are decoded from the controller state, and for boundary-chain capture, data shift and update also from the instruction
            case (s_q.st)
                ST_TLR: begin
                    s_d.ir = BST_IR_IDCODE;
                end
                ST_CAP_DR: begin
                    s_d.byp   = 1'b0;
                    s_d.id_sh = BST_IDCODE;
                    if (dr_sel(s_q.ir) == SEL_BSR) begin
                        for (int k = 0; k < BST_N_MC; k++) begin
                            s_d.bsr[BST_MC_BASE + k] = i_mc_state[k];
                        end
                        for (int k = 0; k < BST_N_IN; k++) begin
                            s_d.bsr[BST_IN_BASE + k] = s_q.sy2_ded[k];
                        end
                        for (int k = 0; k < BST_N_IO; k++) begin
                            s_d.bsr[BST_IO_BASE + BST_IO_CELLS * k
                                    + BST_F_IN]  = s_q.sy2_io[k];
                            s_d.bsr[BST_IO_BASE + BST_IO_CELLS * k
                                    + BST_F_OUT] = i_core_out[k];
                            s_d.bsr[BST_IO_BASE + BST_IO_CELLS * k
                                    + BST_F_OE]  = i_core_oe[k];
                        end
                    end
                end
                ST_SH_DR: begin
                    case (dr_sel(s_q.ir))
                        SEL_BSR: s_d.bsr = {pop_tdi,
                                            s_q.bsr[BST_BSR_LEN-1:1]};
                        SEL_ID:  s_d.id_sh = {pop_tdi,
                                              s_q.id_sh[BST_ID_LEN-1:1]};
                        default: s_d.byp = pop_tdi;
                    endcase
                end
                ST_UPD_DR: begin
                    if (dr_sel(s_q.ir) == SEL_BSR) begin
                        for (int k = 0; k < BST_N_IO; k++) begin
                            s_d.upd_out[k] = s_q.bsr[BST_IO_BASE
                                + BST_IO_CELLS * k + BST_F_OUT];
                            s_d.upd_oe[k]  = s_q.bsr[BST_IO_BASE
                                + BST_IO_CELLS * k + BST_F_OE];
                        end
                    end
                end
                ST_CAP_IR: begin
                    s_d.ir_sh = BST_IR_CAPTURE;
                end
                ST_SH_IR: begin
                    s_d.ir_sh = {pop_tdi, s_q.ir_sh[BST_IR_LEN-1:1]};
                end
                ST_UPD_IR: begin
                    s_d.ir = s_q.ir_sh;
                end
                default: begin
                end
            endcase
            s_d.st = tap_next(s_q.st, pop_tms);
        end
        // serial output moves only on the falling test clock
        if (tck_fall) begin
            s_d.tdo_oe = i_jtag_en
                && (s_q.st == ST_SH_DR || s_q.st == ST_SH_IR);
            if (s_q.st == ST_SH_IR) begin
                s_d.tdo = s_q.ir_sh[0];
            end else begin
                case (dr_sel(s_q.ir))
                    SEL_BSR: s_d.tdo = s_q.bsr[0];
                    SEL_ID:  s_d.tdo = s_q.id_sh[0];
                    default: s_d.tdo = s_q.byp;
                endcase
            end
        end
        if (i_jtag_en) begin
            s_d.tap_out    = '0;
            s_d.tap_oe     = '0;
            s_d.tap_out[BST_P_TDO] = s_q.tdo;
            s_d.tap_oe[BST_P_TDO]  = s_q.tdo_oe;
            s_d.usr_tap_in = '0;
        end else begin
            s_d.tap_out    = i_usr_tap_out;
            s_d.tap_oe     = i_usr_tap_oe;
            s_d.usr_tap_in = s_q.sy2_tap;
        end
        s_d.tms_pu   = i_pullup_en && i_jtag_en;
        s_d.tdi_pu   = i_pullup_en && i_jtag_en;
        s_d.core_in  = s_q.sy2_io;
        s_d.core_ded = s_q.sy2_ded;
        case (s_q.ir)
            BST_IR_EXTEST: begin
                s_d.pin_out = s_q.upd_out;
                s_d.pin_oe  = s_q.upd_oe;
            end
            BST_IR_HIGHZ: begin
                s_d.pin_out = i_core_out;
                s_d.pin_oe  = '0;
            end
            default: begin
                s_d.pin_out = i_core_out;
                s_d.pin_oe  = i_core_oe;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q    <= '0;
            s_q.ir <= BST_IR_IDCODE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tap_pin_out  = s_q.tap_out;
    assign o_tap_pin_oe   = s_q.tap_oe;
    assign o_usr_tap_in   = s_q.usr_tap_in;
    assign o_tms_pu       = s_q.tms_pu;
    assign o_tdi_pu       = s_q.tdi_pu;
    assign o_pin_out      = s_q.pin_out;
    assign o_pin_oe       = s_q.pin_oe;
    assign o_core_in      = s_q.core_in;
    assign o_core_ded     = s_q.core_ded;
    assign o_link_overrun = s_q.overrun;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    reset_state_a: assert property (disable iff (1'b0)
        !i_rst_n |=> (s_q.st == ST_TLR && s_q.ir == BST_IR_IDCODE))
        else $error("controller not in reset state after reset");
    highz_pins_a: assert property (
        (s_q.ir == BST_IR_HIGHZ) |=> (o_pin_oe == '0))
        else $error("pins driven under highz");
    chain_shift_a: assert property (
        (pop && i_jtag_en && s_q.st == ST_SH_DR
         && dr_sel(s_q.ir) == SEL_BSR)
        |=> s_q.bsr == {$past(pop_tdi), $past(s_q.bsr[BST_BSR_LEN-1:1])})
        else $error("boundary chain did not shift by one");
    capture_pin_a: assert property (
        (pop && i_jtag_en && s_q.st == ST_CAP_DR
         && s_q.ir == BST_IR_SAMPLE)
        |=> (s_q.bsr[BST_IO_BASE] == $past(s_q.sy2_io[0])
             && s_q.bsr[BST_MC_BASE] == $past(i_mc_state[0])))
        else $error("capture missed a live signal");
    update_cell_a: assert property (
        (pop && i_jtag_en && s_q.st == ST_UPD_DR
         && s_q.ir == BST_IR_EXTEST)
        ##1 (s_q.ir == BST_IR_EXTEST)
        |=> (o_pin_out[0] == $past(s_q.bsr[BST_IO_BASE + BST_F_OUT], 2)))
        else $error("extest pin does not follow updated cell");
    strobe_source_a: assert property (
        !pop |=> $stable(s_q.bsr))
        else $error("chain moved without a controller step");
    user_io_a: assert property (
        !i_jtag_en ##1 !i_jtag_en
        |-> (o_tap_pin_oe == $past(i_usr_tap_oe)
             && s_q.st == ST_TLR))
        else $error("test pins not released to user logic");
    pullup_a: assert property (
        (i_pullup_en && i_jtag_en) |=> (o_tms_pu && o_tdi_pu))
        else $error("pull-up not applied");
    tdo_fall_a: assert property (
        (tck_fall && i_jtag_en && s_q.st == ST_SH_DR)
        |=> s_q.tdo_oe ##1 o_tap_pin_oe[BST_P_TDO])
        else $error("serial output not enabled after falling edge");
    tms_reset_a: assert property (
        (pop && pop_tms && i_jtag_en && s_q.st == ST_SEL_IR)
        |=> (s_q.st == ST_TLR))
        else $error("controller missed its reset path");
endmodule // bst_tap

// ---- dv/bst_tester.sv ----
`timescale 1ns/1ps
// far-side test controller; tck rests low between frames
module bst_tester (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // one 125 ns period; tdo read late in the low phase
    task automatic tick(input logic tms, input logic tdi,
                        output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #62.5;
        tdo = i_tdo;
        o_tck = 1'b1;
        #62.5;
        o_tck = 1'b0;
    endtask

    // five ones reach reset from any state, then idle
    task automatic to_idle();
        logic d;
        for (int i = 0; i < 5; i++) begin
            tick(1'b1, 1'b1, d);
        end
        tick(1'b0, 1'b1, d);
    endtask

    // idle to idle, n bits lsb first through dr or ir
    task automatic scan(input bit ir, input int n,
                        input logic [271:0] din,
                        output logic [271:0] dout);
        logic d;
        dout = '0;
        tick(1'b1, 1'b0, d);
        if (ir) begin
            tick(1'b1, 1'b0, d);
        end
        tick(1'b0, 1'b0, d);
        tick(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
        end
        tick(1'b1, 1'b0, d);
        tick(1'b0, 1'b0, d);
    endtask
endmodule // bst_tester

// ---- dv/boundary_scan_tap_chain_tb_top.sv ----
`timescale 1ns/1ps
module boundary_scan_tap_chain_tb_top;
    import bst_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n, jtag_en, pu_en, tms_pu, tdi_pu, overrun;
    logic         tck, tms, tdi, tdo_last = 1'b0;
    logic [3:0]   pad, usr_out, usr_oe, usr_in, tp_out, tp_oe;
    logic [3:0]   ded_in, core_ded;
    logic [67:0]  pin_in, pin_out, pin_oe, core_in, core_out, core_oe;
    logic [63:0]  mc_state;
    int           miscompares = 0;
    int           cmp_count = 0;

    always #5 clk = ~clk;

    // tdo line shows the inverse of its last value once released
    assign pad = {tp_oe[3] ? tp_out[3] : ~tdo_last,
                  tp_oe[2] ? tp_out[2] : tck,
                  tp_oe[1] ? tp_out[1] : tms,
                  tp_oe[0] ? tp_out[0] : tdi};
    always @(posedge clk) begin
        if (tp_oe[3]) begin
            tdo_last <= tp_out[3];
        end
    end

    bst_tester u_tst (
        .o_tck (tck),
        .o_tms (tms),
        .o_tdi (tdi),
        .i_tdo (pad[3])
    );

    bst_tap dut (
        .i_clk          (clk),
        .i_rst_n        (rst_n),
        .i_jtag_en      (jtag_en),
        .i_pullup_en    (pu_en),
        .i_tap_pin      (pad),
        .o_tap_pin_out  (tp_out),
        .o_tap_pin_oe   (tp_oe),
        .i_usr_tap_out  (usr_out),
        .i_usr_tap_oe   (usr_oe),
        .o_usr_tap_in   (usr_in),
        .o_tms_pu       (tms_pu),
        .o_tdi_pu       (tdi_pu),
        .i_pin_in       (pin_in),
        .o_pin_out      (pin_out),
        .o_pin_oe       (pin_oe),
        .i_ded_in       (ded_in),
        .o_core_ded     (core_ded),
        .o_core_in      (core_in),
        .i_core_out     (core_out),
        .i_core_oe      (core_oe),
        .i_mc_state     (mc_state),
        .o_link_overrun (overrun)
    );

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [271:0] seen, input logic [271:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: seen %0h want %0h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic t_func();
        chk(tp_oe, 4'h0, "tdo idle enable");
        core_out = 68'h5_A5A5_0F0F_3C3C_9696;
        core_oe = ~core_out;
        pin_in = 68'hC_3C3C_1234_5678_9ABC;
        ded_in = 4'h9;
        step(4);
        chk(pin_out, core_out, "pin drive");
        chk(pin_oe, core_oe, "pin enable");
        chk(core_in, pin_in, "core input");
        chk(core_ded, ded_in, "dedicated input");
        $display("t_func done");
    endtask

    task automatic t_idcode();
        logic [271:0] q;
        u_tst.to_idle();
        u_tst.scan(1'b0, BST_ID_LEN, '0, q);
        chk(q[31:0], BST_IDCODE, "reset idcode");
        u_tst.scan(1'b1, BST_IR_LEN, 272'(BST_IR_IDCODE), q);
        chk(q[3:0], BST_IR_CAPTURE, "ir capture");
        u_tst.scan(1'b0, BST_ID_LEN, '0, q);
        chk(q[31:0], BST_IDCODE, "idcode");
        $display("t_idcode done");
    endtask

    task automatic t_bypass();
        logic [271:0] q;
        logic [3:0]   codes [2] = '{BST_IR_BYPASS, 4'h7};
        foreach (codes[i]) begin
            u_tst.scan(1'b1, BST_IR_LEN, 272'(codes[i]), q);
            u_tst.scan(1'b0, 8, 272'h00B6, q);
            chk(q[7:0], 8'h6C, "bypass");
        end
        $display("t_bypass done");
    endtask

    task automatic t_sample_extest();
        logic [271:0] q, d, e;
        step(1);
        mc_state = 64'hDEAD_BEEF_0123_4567;
        d = '0;
        d[BST_IO_BASE + BST_F_OUT] = 1'b1;
        d[BST_IO_BASE + BST_F_OE] = 1'b1;
        e = '0;
        e[BST_MC_BASE +: BST_N_MC] = mc_state;
        e[BST_IN_BASE +: BST_N_IN] = ded_in;
        for (int k = 0; k < BST_N_IO; k++) begin
            e[BST_IO_BASE + 3 * k +: 3] = {core_oe[k], core_out[k],
                                          pin_in[k]};
        end
        u_tst.scan(1'b1, BST_IR_LEN, 272'(BST_IR_SAMPLE), q);
        u_tst.scan(1'b0, BST_BSR_LEN, d, q);
        chk(q, e, "sample chain");
        chk(pin_out, core_out, "sample keeps pins");
        u_tst.scan(1'b1, BST_IR_LEN, 272'(BST_IR_EXTEST), q);
        step(2);
        chk(pin_out, 68'h1, "extest drive");
        chk(pin_oe, 68'h1, "extest enable");
        d[BST_IO_BASE + BST_F_OUT] = 1'b0;
        d[BST_IO_BASE + BST_IO_CELLS + BST_F_OUT] = 1'b1;
        d[BST_IO_BASE + BST_IO_CELLS + BST_F_OE] = 1'b1;
        u_tst.scan(1'b0, BST_BSR_LEN, d, q);
        chk(q, e, "extest capture");
        step(2);
        chk(pin_out, 68'h2, "extest update drive");
        chk(pin_oe, 68'h3, "extest update enable");
        $display("t_sample_extest done");
    endtask

    task automatic t_highz();
        logic [271:0] q;
        core_oe = '1;
        u_tst.scan(1'b1, BST_IR_LEN, 272'(BST_IR_HIGHZ), q);
        step(2);
        chk(pin_oe, 68'h0, "highz");
        u_tst.to_idle();
        step(2);
        chk(pin_oe, core_oe, "pins back to core");
        $display("t_highz done");
    endtask

    task automatic t_config();
        logic [271:0] q;
        logic         b;
        pu_en = 1'b1;
        step(2);
        chk({tms_pu, tdi_pu}, 2'b11, "pull-up on");
        usr_out = 4'hA;
        usr_oe = 4'h9;
        jtag_en = 1'b0;
        step(2);
        chk({tms_pu, tdi_pu}, 2'b00, "pull-up off");
        chk(tp_out, usr_out, "user drive");
        chk(tp_oe, usr_oe, "user enable");
        u_tst.scan(1'b1, BST_IR_LEN, 272'(BST_IR_BYPASS), q);
        step(4);
        chk(usr_in, pad, "user input");
        usr_oe = 4'h0;
        jtag_en = 1'b1;
        step(2);
        u_tst.tick(1'b0, 1'b1, b);
        u_tst.scan(1'b0, BST_ID_LEN, '0, q);
        chk(q[31:0], BST_IDCODE, "reset while off");
        chk(overrun, 1'b0, "no overrun");
        u_tst.scan(1'b1, BST_IR_LEN, 272'(BST_IR_BYPASS), q);
        step(1);
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(2);
        chk(tp_oe, 4'h0, "tdo idle after reset");
        u_tst.tick(1'b0, 1'b1, b);
        u_tst.scan(1'b0, BST_ID_LEN, '0, q);
        chk(q[31:0], BST_IDCODE, "idcode after reset");
        $display("t_config done");
    endtask

    initial begin
        rst_n = 1'b0;
        jtag_en = 1'b1;
        pu_en = 1'b0;
        usr_out = 4'h0;
        usr_oe = 4'h0;
        pin_in = '0;
        ded_in = 4'h0;
        core_out = '0;
        core_oe = '0;
        mc_state = '0;
        step(5);
        rst_n = 1'b1;
        step(2);
        t_func();
        t_idcode();
        t_bypass();
        t_sample_extest();
        t_highz();
        t_config();
        report_and_stop();
    end

    // cuts a hang short well inside the run budget
    initial begin
        #900_000;
        miscompares++;
        $display("[ERR] %0t run timed out", $time);
        report_and_stop();
    end
endmodule // boundary_scan_tap_chain_tb_top
